// ---- core/cmp_ctrl_pkg.sv ----
package cmp_ctrl_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL0_ADDR = 4'h0;
	localparam logic [3:0] CTRL1_ADDR = 4'h4;
	localparam logic [3:0] SHARED_ADDR = 4'h8;
	localparam logic [3:0] IRQ_ADDR = 4'hC;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int EN_BIT = 7;
	localparam int RES_BIT = 6;
	localparam int OE_BIT = 5;
	localparam int POL_BIT = 4;
	localparam int SP_BIT = 3;
	localparam int NSRC_BIT = 2;
	localparam int CH_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h08;

	// ----------------------------------------------------------------
	// shared register fields (mirror 7/6, refsel 5/4, hys 3/2, sync 1/0)
	// ----------------------------------------------------------------
	localparam int MIR1_BIT = 7;
	localparam int MIR2_BIT = 6;
	localparam int RSEL1_BIT = 5;
	localparam int RSEL2_BIT = 4;
	localparam int HYS1_BIT = 3;
	localparam int HYS2_BIT = 2;
	localparam int SYNC1_BIT = 1;
	localparam int SYNC2_BIT = 0;
	localparam logic [5:0] SHARED_RESET = 6'h00;

	// ----------------------------------------------------------------
	// irq register fields: flags 1:0, enables 3:2, gates 5:4
	// ----------------------------------------------------------------
	localparam int FLAG_LSB = 0;
	localparam int IE_LSB = 2;
	localparam int PEIE_BIT = 4;
	localparam int GIE_BIT = 5;

	// ----------------------------------------------------------------
	// four-phase instruction cycle
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_ONE = 4'h1,
		PH_TWO = 4'h2,
		PH_THREE = 4'h4,
		PH_FOUR = 4'h8
	} phase_t;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- core/cmp_ctrl.sv ----
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Contract
// - raw result high when plus exceeds minus
// - polarity bit inverts reported result
// - enable activates; disabled gives raw zero
// - disabled result set only by polarity
// - channel field picks one of four pins
// - source bit picks reference node or pin
// - refsel picks fixed reference or converter
// - pin output needs oe, pin_direction clear, enable
// - oe overrides port latch regardless of enable
// - internal result latched per instruction cycle
// - result readable in control and shared
// - shared read leaves mismatch latches alone
// - speed bit resets to one
// - first latch loads on control access
// - second latch loads every phase one
// - mismatch is xor of both latches
// - write reloads first latch, clears mismatch
// - flag sets on mismatch rising edge
// - software clears flag with zero, one sets
// - detection independent of output enable
// - irq needs enable and both gates
// - phase-two read change may lose flag
// - phase one runs during sleep
// - change wakes with enable and peripheral gate
// - reset returns registers to reset values
// - sync mode latches on timer falling edge
module cmp_ctrl (
	input wire logic REF_CLK, // system clock
	input wire logic RESET, // async reset, active high
	input wire logic [3:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [3:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read valid
	input wire logic S_AXI_RREADY, // read ready
	input wire logic [1:0] RAW_COMPARE, // analog comparator outputs, async
	input wire logic [1:0] TIMER_CLK, // timer source clock per comparator, async
	input wire logic [1:0] PIN_DIRECTION, // port direction bits, 1 = input
	input wire logic [1:0] PORT_LATCH, // port data latch bits
	input wire logic SLEEP, // device in sleep, phases halted
	output logic [1:0] CMP_ENABLE, // analog enable per comparator
	output logic [1:0] SPEED_POWER, // 1 = high speed
	output logic [1:0] NONINV_SRC, // 1 = reference node, 0 = pin
	output logic [1:0] REF_SRC, // 1 = fixed reference, 0 = converter
	output logic [3:0] INV_CHANNEL, // channel per comparator, 2 bits each
	output logic [1:0] HYSTERESIS, // hysteresis enable
	output logic [1:0] PIN_OUT, // pin level
	output logic [1:0] PIN_OE_N, // pin driver enable, low = driving
	output logic [1:0] TIMER_GATE_OUT, // result to timer gate / set-reset latch
	output logic [1:0] PWM_OUT, // unsynchronized result to pwm logic
	output logic IRQ_REQ, // interrupt request
	output logic WAKE // wake from sleep request
);

	typedef struct packed {
		logic [1:0][7:0] ctrl;
		logic [5:0] shared;
		logic [1:0] flag;
		logic [1:0] ie;
		logic peie;
		logic gie;
		logic [1:0] res_int;
		logic [1:0] lat_one;
		logic [1:0] lat_two;
		logic [1:0] mis_prev;
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic [1:0] tclk_a;
		logic [1:0] tclk_b;
		logic [1:0] tclk_prev;
		logic [1:0] tsync;
		cmp_ctrl_pkg::phase_t ph;
		logic [1:0] rd_pend;
		logic [1:0] acc_p3;
		logic aw_got;
		logic w_got;
		logic [3:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] pin_out;
		logic [1:0] pin_oe_n;
		logic [1:0] tg_out;
		logic [1:0] pwm;
		logic irq;
		logic wake;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [1:0] en;
	logic [1:0] pol;
	logic [1:0] mismatch;
	logic [1:0] reported;
	logic wr_fire;
	logic rd_fire;
	logic [1:0] sync_sel;

	// ----------------------------------------------------------------
	// per-comparator combinational view
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			en[i] = s_q.ctrl[i][cmp_ctrl_pkg::EN_BIT];
			pol[i] = s_q.ctrl[i][cmp_ctrl_pkg::POL_BIT];
			// disabled comparator feeds zero to the polarity stage
			reported[i] = (s_q.sync_b[i] & en[i]) ^ pol[i];
			mismatch[i] = s_q.lat_one[i] ^ s_q.lat_two[i];
		end
		sync_sel[0] = s_q.shared[cmp_ctrl_pkg::SYNC1_BIT];
		sync_sel[1] = s_q.shared[cmp_ctrl_pkg::SYNC2_BIT];
	end

	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign rd_fire = S_AXI_ARVALID && !s_q.rvalid;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] set_ev;
		logic [1:0] acc;
		logic [7:0] wb;
		set_ev = 2'h0;
		acc = 2'h0;
		wb = 8'h00;
		s_d = s_q;

		// input synchronisers
		s_d.sync_a = RAW_COMPARE;
		s_d.sync_b = s_q.sync_a;
		s_d.tclk_a = TIMER_CLK;
		s_d.tclk_b = s_q.tclk_a;
		s_d.tclk_prev = s_q.tclk_b;

		// phase sequencer; sleep parks it on phase one
		if (SLEEP) begin
			s_d.ph = cmp_ctrl_pkg::PH_ONE;
		end else begin
			unique case (s_q.ph)
				cmp_ctrl_pkg::PH_ONE: s_d.ph = cmp_ctrl_pkg::PH_TWO;
				cmp_ctrl_pkg::PH_TWO: s_d.ph = cmp_ctrl_pkg::PH_THREE;
				cmp_ctrl_pkg::PH_THREE: s_d.ph = cmp_ctrl_pkg::PH_FOUR;
				cmp_ctrl_pkg::PH_FOUR: s_d.ph = cmp_ctrl_pkg::PH_ONE;
				default: s_d.ph = cmp_ctrl_pkg::PH_ONE;
			endcase
		end

		// axi write channel
		if (S_AXI_AWVALID && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.wdata = S_AXI_WDATA;
			s_d.wstrb = S_AXI_WSTRB;
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = cmp_ctrl_pkg::RESP_OKAY;
			wb = s_q.wstrb[0] ? s_q.wdata[7:0] : 8'h00;
			unique case (s_q.awaddr)
				cmp_ctrl_pkg::CTRL0_ADDR, cmp_ctrl_pkg::CTRL1_ADDR: begin
					if (s_q.wstrb[0]) begin
						for (int i = 0; i < 2; i++) begin
							if (s_q.awaddr[2] == 1'(i)) begin
								s_d.ctrl[i] = wb;
								s_d.ctrl[i][cmp_ctrl_pkg::RES_BIT] = 1'b0;
								acc[i] = 1'b1;
							end
						end
					end
				end
				cmp_ctrl_pkg::SHARED_ADDR: begin
					if (s_q.wstrb[0]) begin
						s_d.shared = wb[5:0];
					end
				end
				cmp_ctrl_pkg::IRQ_ADDR: begin
					if (s_q.wstrb[0]) begin
						s_d.flag = wb[cmp_ctrl_pkg::FLAG_LSB +: 2];
						s_d.ie = wb[cmp_ctrl_pkg::IE_LSB +: 2];
						s_d.peie = wb[cmp_ctrl_pkg::PEIE_BIT];
						s_d.gie = wb[cmp_ctrl_pkg::GIE_BIT];
					end
				end
				default: s_d.bresp = cmp_ctrl_pkg::RESP_SLVERR;
			endcase
		end

		// axi read channel
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = cmp_ctrl_pkg::RESP_OKAY;
			s_d.rdata = 32'h0000_0000;
			unique case (S_AXI_ARADDR)
				cmp_ctrl_pkg::CTRL0_ADDR, cmp_ctrl_pkg::CTRL1_ADDR: begin
					for (int i = 0; i < 2; i++) begin
						if (S_AXI_ARADDR[2] == 1'(i)) begin
							s_d.rdata[7:0] = s_q.ctrl[i];
							s_d.rdata[cmp_ctrl_pkg::RES_BIT] = s_q.res_int[i];
							acc[i] = 1'b1;
						end
					end
				end
				cmp_ctrl_pkg::SHARED_ADDR: begin
					// mirror read does not touch the mismatch latches
					s_d.rdata[5:0] = s_q.shared;
					s_d.rdata[cmp_ctrl_pkg::MIR1_BIT] = s_q.res_int[0];
					s_d.rdata[cmp_ctrl_pkg::MIR2_BIT] = s_q.res_int[1];
				end
				cmp_ctrl_pkg::IRQ_ADDR: begin
					s_d.rdata[cmp_ctrl_pkg::FLAG_LSB +: 2] = s_q.flag;
					s_d.rdata[cmp_ctrl_pkg::IE_LSB +: 2] = s_q.ie;
					s_d.rdata[cmp_ctrl_pkg::PEIE_BIT] = s_q.peie;
					s_d.rdata[cmp_ctrl_pkg::GIE_BIT] = s_q.gie;
				end
				default: s_d.rresp = cmp_ctrl_pkg::RESP_SLVERR;
			endcase
		end

		// a control access is held until the next phase three
		s_d.rd_pend = s_q.rd_pend | acc;
		s_d.acc_p3 = 2'h0;
		for (int i = 0; i < 2; i++) begin
			if (s_q.ph == cmp_ctrl_pkg::PH_ONE) begin
				s_d.lat_two[i] = reported[i];
				s_d.res_int[i] = reported[i];
			end
			if (s_q.ph == cmp_ctrl_pkg::PH_THREE && s_q.rd_pend[i]) begin
				s_d.lat_one[i] = s_q.lat_two[i];
				s_d.rd_pend[i] = acc[i];
				s_d.acc_p3[i] = 1'b1;
			end
			// edge of mismatch sets flag; a refresh that cancels it first loses it
			set_ev[i] = mismatch[i] & ~s_q.mis_prev[i];
			s_d.mis_prev[i] = mismatch[i];
			if (set_ev[i]) begin
				s_d.flag[i] = 1'b1;
			end
			// timer-synchronous capture on falling edge of the timer clock
			if (s_q.tclk_prev[i] && !s_q.tclk_b[i]) begin
				s_d.tsync[i] = reported[i];
			end
			s_d.tg_out[i] = sync_sel[i] ? s_q.tsync[i] : reported[i];
			s_d.pwm[i] = reported[i];
			// oe takes the pin from the port latch whatever the enable state
			s_d.pin_out[i] = s_q.ctrl[i][cmp_ctrl_pkg::OE_BIT] ?
				(reported[i] & en[i]) : PORT_LATCH[i];
			s_d.pin_oe_n[i] = !(s_q.ctrl[i][cmp_ctrl_pkg::OE_BIT] ?
				(en[i] && !PIN_DIRECTION[i]) : !PIN_DIRECTION[i]);
		end
		s_d.irq = |(s_d.flag & s_q.ie) && s_q.peie && s_q.gie;
		s_d.wake = |(s_d.flag & s_q.ie) && s_q.peie;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			s_q <= '0;
			s_q.ctrl <= {cmp_ctrl_pkg::CTRL_RESET, cmp_ctrl_pkg::CTRL_RESET};
			s_q.shared <= cmp_ctrl_pkg::SHARED_RESET;
			// pin drivers stay released while in reset
			s_q.pin_oe_n <= 2'h3;
			s_q.ph <= cmp_ctrl_pkg::PH_ONE;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = !s_q.aw_got;
	assign S_AXI_WREADY = !s_q.w_got;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = !s_q.rvalid;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RDATA = s_q.rdata;
	assign S_AXI_RRESP = s_q.rresp;
	assign PIN_OUT = s_q.pin_out;
	assign PIN_OE_N = s_q.pin_oe_n;
	assign TIMER_GATE_OUT = s_q.tg_out;
	assign PWM_OUT = s_q.pwm;
	assign IRQ_REQ = s_q.irq;
	assign WAKE = s_q.wake;
	assign CMP_ENABLE = {s_q.ctrl[1][cmp_ctrl_pkg::EN_BIT], s_q.ctrl[0][cmp_ctrl_pkg::EN_BIT]};
	assign SPEED_POWER = {s_q.ctrl[1][cmp_ctrl_pkg::SP_BIT], s_q.ctrl[0][cmp_ctrl_pkg::SP_BIT]};
	assign NONINV_SRC = {s_q.ctrl[1][cmp_ctrl_pkg::NSRC_BIT],
		s_q.ctrl[0][cmp_ctrl_pkg::NSRC_BIT]};
	assign INV_CHANNEL = {s_q.ctrl[1][cmp_ctrl_pkg::CH_LSB +: 2],
		s_q.ctrl[0][cmp_ctrl_pkg::CH_LSB +: 2]};
	assign REF_SRC = {s_q.shared[cmp_ctrl_pkg::RSEL2_BIT],
		s_q.shared[cmp_ctrl_pkg::RSEL1_BIT]};
	assign HYSTERESIS = {s_q.shared[cmp_ctrl_pkg::HYS2_BIT], s_q.shared[cmp_ctrl_pkg::HYS1_BIT]};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_mis_rise(int i);
		!s_q.mis_prev[i] ##1 s_q.mis_prev[i];
	endsequence

	chk_flag_on_edge: assert property (@(posedge REF_CLK) disable iff (RESET)
		(mismatch[0] && !s_q.mis_prev[0]) |=> s_q.flag[0])
		else $error("flag not set on mismatch edge");

	chk_flag_after_rise: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_mis_rise(1) |-> s_q.flag[1] || $past(wr_fire))
		else $error("flag missing after mismatch rise");

	chk_irq_gates: assert property (@(posedge REF_CLK) disable iff (RESET)
		IRQ_REQ |-> $past(s_q.peie) && $past(s_q.gie))
		else $error("irq without gates");

	chk_wake_gate: assert property (@(posedge REF_CLK) disable iff (RESET)
		WAKE |-> $past(s_q.peie))
		else $error("wake without peripheral gate");

	chk_disabled_level: assert property (@(posedge REF_CLK) disable iff (RESET)
		!en[0] |-> reported[0] == pol[0])
		else $error("disabled result not polarity");

	chk_pin_drive: assert property (@(posedge REF_CLK) disable iff (RESET)
		!PIN_OE_N[0] && $past(s_q.ctrl[0][cmp_ctrl_pkg::OE_BIT]) |-> $past(en[0]))
		else $error("pin driven while disabled");

	chk_first_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
		!s_q.acc_p3[0] && !$past(s_q.acc_p3[0]) |-> $stable(s_q.lat_one[0]) || $past(RESET))
		else $error("first latch moved without access");

	chk_second_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_q.ph == cmp_ctrl_pkg::PH_ONE |=> s_q.lat_two[0] == $past(reported[0]))
		else $error("second latch missed phase one");

	chk_access_clears: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_q.acc_p3[1] |-> s_q.lat_one[1] == $past(s_q.lat_two[1]))
		else $error("access did not reload first latch");

endmodule

// ---- bench/analog_source_model.sv ----
`timescale 1ns/1ps
module analog_source_model (
	input wire logic clk, // sampling clock
	input wire logic [15:0] v_plus, // noninverting level, 8 bits per comparator
	input wire logic [15:0] v_minus, // inverting level, 8 bits per comparator
	output logic [1:0] raw_out, // raw comparator outputs
	output logic [1:0] timer_out // timer source clocks
);
	logic [2:0] div_q = 3'h0;
	initial begin
		raw_out = 2'h0;
		timer_out = 2'h0;
	end
	// ----------------------------------------
	// comparison and timer clock
	// ----------------------------------------
	always @(posedge clk) begin
		raw_out[0] <= v_plus[7:0] > v_minus[7:0];
		raw_out[1] <= v_plus[15:8] > v_minus[15:8];
		div_q <= div_q + 3'h1;
		timer_out <= {div_q[2], div_q[2]};
	end
endmodule

// ---- bench/test_analog_comparator_control.sv ----
`timescale 1ns/1ps
module test_analog_comparator_control;
	typedef struct packed {
		logic [1:0] resp;
		logic [31:0] data;
		logic [31:0] mask;
	} exp_t;
	localparam logic [3:0] A_C0 = cmp_ctrl_pkg::CTRL0_ADDR;
	localparam logic [3:0] A_C1 = cmp_ctrl_pkg::CTRL1_ADDR;
	localparam logic [3:0] A_SH = cmp_ctrl_pkg::SHARED_ADDR;
	localparam logic [3:0] A_IRQ = cmp_ctrl_pkg::IRQ_ADDR;
	logic clk = 1'h0, rst = 1'h1, sleep = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, chan;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0] pin_dir = 2'h3, port_latch = 2'h0, raw, tclk, cmp_en, speed, nsrc, rsrc;
	logic [1:0] hys, pin_out, oe_n, tgate, pwm, bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, irq, wake;
	logic [15:0] v_plus = 16'h0, v_minus = 16'h0;
	logic [13:0] x;
	exp_t exp_q[$];
	exp_t e;
	logic [1:0] expb_q[$];
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 75504;

	always #4 clk = ~clk;

	cmp_ctrl cmp_ctrl_inst (.REF_CLK(clk), .RESET(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.RAW_COMPARE(raw), .TIMER_CLK(tclk), .PIN_DIRECTION(pin_dir), .PORT_LATCH(port_latch),
		.SLEEP(sleep), .CMP_ENABLE(cmp_en), .SPEED_POWER(speed), .NONINV_SRC(nsrc),
		.REF_SRC(rsrc), .INV_CHANNEL(chan), .HYSTERESIS(hys), .PIN_OUT(pin_out),
		.PIN_OE_N(oe_n), .TIMER_GATE_OUT(tgate), .PWM_OUT(pwm), .IRQ_REQ(irq), .WAKE(wake));

	analog_source_model analog_source_model_inst (.clk(clk), .v_plus(v_plus),
		.v_minus(v_minus), .raw_out(raw), .timer_out(tclk));

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_cfg(input logic [13:0] exp, input logic [13:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] routing expected %h seen %h", exp, got);
		end
	endtask

	task automatic cmp_rd(input exp_t q, input logic [1:0] r, input logic [31:0] d);
		comparisons++;
		if (r !== q.resp || (d & q.mask) !== (q.data & q.mask)) begin
			n_mismatch++;
			$display("[FAIL] read expected %h/%h seen %h/%h", q.resp, q.data, r, d);
		end
	endtask

	task automatic cmp_resp(input logic [1:0] exp, input logic [1:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] bresp expected %h seen %h", exp, got);
		end
	endtask

	always @(posedge clk) begin
		if (rvalid && rready) begin
			e = exp_q.pop_front();
			cmp_rd(e, rresp, rdata);
		end
		if (bvalid && bready) begin
			cmp_resp(expb_q.pop_front(), bresp);
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end

	// ----------------------------------------
	// bus and analog drivers
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d,
		input logic [1:0] r = cmp_ctrl_pkg::RESP_OKAY);
		@(posedge clk);
		expb_q.push_back(r);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		repeat (64) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m,
		input logic [1:0] r = cmp_ctrl_pkg::RESP_OKAY);
		@(posedge clk);
		exp_q.push_back('{r, {24'h0, d}, {24'hFFFFFF, m}});
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		repeat (64) begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
	endtask

	task automatic analog(input int i, input logic hi);
		logic [7:0] m;
		@(posedge clk);
		m = 8'h50 + 8'($random(seed) & 32'h3F);
		v_minus[i*8+:8] <= m;
		v_plus[i*8+:8] <= hi ? m + 8'h14 : m - 8'h14;
	endtask

	task automatic settle;
		repeat (12) @(posedge clk);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		wr(4'h2, 8'hFF, cmp_ctrl_pkg::RESP_SLVERR);
		rd(A_C0, 8'h08, 8'hFF);
		rd(A_C1, 8'h08, 8'hFF);
		rd(A_SH, 8'h00, 8'h3F);
		rd(4'h2, 8'h00, 8'h00, cmp_ctrl_pkg::RESP_SLVERR);
		cmp_bit("speed0", 1'h1, speed[0]);
		analog(0, 1'h1);
		analog(1, 1'h0);
		for (int p = 0; p < 2; p++) begin
			wr(A_C0, p ? 8'h10 : 8'h00);
			settle();
			rd(A_C0, p ? 8'h50 : 8'h00, 8'hFF);
		end
		cmp_bit("speed0", 1'h0, speed[0]);
		wr(A_C0, 8'h88);
		repeat (125) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			analog(0, k[0]);
			wr(A_C0, k[1] ? 8'h98 : 8'h88);
			settle();
			rd(A_C0, {1'h1, k[0] ^ k[1], 1'h0, k[1], 4'h8}, 8'hFF);
			rd(A_SH, {k[0] ^ k[1], 7'h0}, 8'h80);
		end
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			v[1:0] = 2'(i);
			v[9:8] = 2'(3 - i);
			wr(A_C0, v[7:0]);
			wr(A_C1, v[15:8]);
			wr(A_SH, v[23:16]);
			@(posedge clk);
			x = {v[15], v[7], v[11], v[3], v[10], v[2], v[9:8], v[1:0], v[20], v[21], v[18], v[19]};
			cmp_cfg(x, {cmp_en, speed, nsrc, chan, rsrc, hys});
			rd(A_C1, v[15:8], 8'hBF);
			rd(A_SH, {2'h0, v[21:16]}, 8'h3F);
		end
		wr(A_C1, 8'h08);
		wr(A_SH, 8'h00);
		analog(0, 1'h0);
		wr(A_C0, 8'hA8);
		settle();
		rd(A_C0, 8'hA8, 8'hFF);
		wr(A_IRQ, 8'h00);
		pin_dir <= 2'h2;
		analog(0, 1'h1);
		settle();
		rd(A_SH, 8'h80, 8'h80);
		rd(A_IRQ, 8'h01, 8'h3D);
		cmp_bit("pin_oe_n", 1'h0, oe_n[0]);
		cmp_bit("pin_out", 1'h1, pin_out[0]);
		cmp_bit("pwm", 1'h1, pwm[0]);
		wr(A_IRQ, 8'h00);
		settle();
		rd(A_IRQ, 8'h00, 8'h3D);
		wr(A_IRQ, 8'h05);
		settle();
		cmp_bit("irq", 1'h0, irq);
		rd(A_IRQ, 8'h05, 8'h3D);
		wr(A_IRQ, 8'h35);
		settle();
		cmp_bit("irq", 1'h1, irq);
		wr(A_IRQ, 8'h04);
		wr(A_C0, 8'hA8);
		settle();
		analog(0, 1'h0);
		settle();
		rd(A_IRQ, 8'h05, 8'h3D);
		pin_dir <= 2'h3;
		settle();
		cmp_bit("pin_oe_n", 1'h1, oe_n[0]);
		wr(A_C0, 8'h88);
		pin_dir <= 2'h2;
		port_latch <= 2'h1;
		settle();
		cmp_bit("pin_out", 1'h1, pin_out[0]);
		wr(A_IRQ, 8'h14);
		sleep <= 1'h1;
		analog(0, 1'h1);
		settle();
		cmp_bit("wake", 1'h1, wake);
		cmp_bit("irq", 1'h0, irq);
		sleep <= 1'h0;
		wr(A_SH, 8'h02);
		settle();
		settle();
		cmp_bit("timer_gate", 1'h1, tgate[0]);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		cmp_bit("enable", 1'h0, cmp_en[0]);
		rst <= 1'h0;
		rd(A_C0, 8'h08, 8'hFF);
		rd(A_IRQ, 8'h00, 8'h3F);
		@(posedge clk);
		tally_and_finish();
	end
endmodule
